// >>> design/dsad_decoder.sv
`timescale 1ns/1ns
// Data space decoder, lane steering, alignment trap and program counter
module dsad_decoder
    import dsad_pkg::*;
#(
    parameter int DMA_BYTES = dsad_dma_bytes_default,
    parameter int DMA_AW = $clog2(DMA_BYTES / 2)
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic pc_advance,
    input wire logic pc_retreat,
    input wire logic pc_load,
    input wire logic [23:0] pc_load_value,
    output logic [23:0] program_counter,
    output logic pc_in_vector_area,
    output logic pc_in_alt_table,
    input wire logic [23:0] prog_word_in,
    output logic [15:0] prog_lower_word,
    output logic [15:0] prog_upper_word,
    input wire logic rd_req,
    input wire logic rd_byte,
    input wire logic rd_near_direct,
    input wire logic [15:0] rd_effective_address,
    output logic [15:0] rd_data,
    output logic rd_psv_sel,
    input wire logic wr_req,
    input wire logic wr_byte,
    input wire logic wr_near_direct,
    input wire logic [15:0] wr_effective_address,
    input wire logic [15:0] wr_data,
    output logic sfr_wr,
    output logic [10:1] sfr_waddr,
    output logic [1:0] sfr_wbe,
    output logic [15:0] sfr_wdata,
    output logic [10:1] sfr_raddr,
    input wire logic [15:0] sfr_rdata,
    input wire logic sfr_rhit,
    output logic address_error_trap,
    input wire logic [15:0] source_pointer_register,
    input wire logic ptr_post_inc,
    output logic [15:0] next_pointer,
    input wire logic [15:0] wreg_old,
    input wire logic [2:0] ext_op,
    output logic [15:0] wreg_new,
    input wire logic dma_wr,
    input wire logic [DMA_AW-1:0] dma_waddr,
    input wire logic [DMA_AW-1:0] dma_raddr,
    input wire logic [1:0] dma_be,
    input wire logic [15:0] dma_wdata,
    output logic [15:0] dma_rdata,
    output logic dma_write_dropped
);
    localparam logic [15:0] dma_base = 16'(dsad_ram_limit - 16'(DMA_BYTES));

    typedef enum logic [3:0] {
        dsad_rgn_sfr = 4'b0001,
        dsad_rgn_ram = 4'b0010,
        dsad_rgn_dma = 4'b0100,
        dsad_rgn_none = 4'b1000
    } dsad_rgn_t;

    typedef struct packed {
        logic [23:0] pc;
        logic psv;
        logic trap;
        dsad_rgn_t rrgn;
        logic rlane;
        logic rbyte;
    } dsad_state_t;

    dsad_state_t st;
    dsad_state_t next_st;
    logic [15:0] rd_ea;
    logic [15:0] wr_ea;
    dsad_rgn_t rd_rgn;
    dsad_rgn_t wr_rgn;
    logic rd_mis;
    logic wr_mis;
    logic [1:0] wr_be;
    logic [15:0] wr_lanes;
    logic [15:0] gen_ram_q;
    logic [15:0] dma_ram_q;
    logic [15:0] raw_word;
    logic [15:0] gen_mem [0:(dsad_ram_limit/2)-1];

    dsad_dma_if #(.AW(DMA_AW)) dma_port ();

    // Region decode of a byte address
    function automatic dsad_rgn_t region(input logic [15:0] ea);
        dsad_rgn_t r;
        r = dsad_rgn_none;
        if (ea[dsad_psv_bit]) begin
            r = dsad_rgn_none;
        end else if (ea <= dsad_sfr_last) begin
            r = dsad_rgn_sfr;
        end else if (ea >= dsad_ram_limit) begin
            r = dsad_rgn_none;
        end else if (ea >= dma_base) begin
            r = dsad_rgn_dma;
        end else begin
            r = dsad_rgn_ram;
        end
        return r;
    endfunction

    // Short direct field reaches only the near space
    assign rd_ea = rd_near_direct ?
        {3'b000, rd_effective_address[dsad_near_field_bits-1:0]} : rd_effective_address;
    assign wr_ea = wr_near_direct ?
        {3'b000, wr_effective_address[dsad_near_field_bits-1:0]} : wr_effective_address;
    assign rd_rgn = region(rd_ea);
    assign wr_rgn = region(wr_ea);
    assign rd_mis = rd_req && !rd_byte && rd_ea[0];
    assign wr_mis = wr_req && !wr_byte && wr_ea[0];

    // Byte write strobes and lane placement
    always_comb begin
        wr_be = 2'b11;
        wr_lanes = wr_data;
        if (wr_byte) begin
            wr_be = wr_ea[0] ? 2'b10 : 2'b01;
            wr_lanes = {wr_data[7:0], wr_data[7:0]};
        end
        if (!wr_req || wr_mis) begin
            wr_be = 2'b00;
        end
    end

    // Special function register write and read ports
    assign sfr_wr = (wr_rgn == dsad_rgn_sfr) && (wr_be != 2'b00);
    assign sfr_waddr = wr_ea[10:1];
    assign sfr_wbe = wr_be;
    assign sfr_wdata = wr_lanes;
    assign sfr_raddr = rd_ea[10:1];

    // General data RAM, word array with per-lane writes
    always_ff @(posedge core_clk) begin
        if (wr_rgn == dsad_rgn_ram) begin
            if (wr_be[0]) begin
                gen_mem[wr_ea[12:1]][7:0] <= wr_lanes[7:0];
            end
            if (wr_be[1]) begin
                gen_mem[wr_ea[12:1]][15:8] <= wr_lanes[15:8];
            end
        end
        gen_ram_q <= gen_mem[rd_ea[12:1]];
    end

    assign dma_port.wr = dma_wr;
    assign dma_port.waddr = dma_waddr;
    assign dma_port.raddr = dma_raddr;
    assign dma_port.be = dma_be;
    assign dma_port.wdata = dma_wdata;
    assign dma_rdata = dma_port.rdata;
    assign dma_write_dropped = dma_port.dropped;

    dsad_dma_ram #(.AW(DMA_AW)) u_dma_ram (
        .core_clk(core_clk),
        .rst(rst),
        .cpu_wr((wr_rgn == dsad_rgn_dma) && (wr_be != 2'b00)),
        .cpu_waddr(DMA_AW'((wr_ea - dma_base) >> 1)),
        .cpu_raddr(DMA_AW'((rd_ea - dma_base) >> 1)),
        .cpu_be(wr_be),
        .cpu_wdata(wr_lanes),
        .cpu_rdata(dma_ram_q),
        .dma(dma_port)
    );

    // Word chosen by last cycle's region, zero where nothing answers
    always_comb begin
        unique case (st.rrgn)
            dsad_rgn_ram: raw_word = gen_ram_q;
            dsad_rgn_dma: raw_word = dma_ram_q;
            dsad_rgn_sfr: raw_word = sfr_rhit ? sfr_rdata : dsad_zero_word;
            dsad_rgn_none: raw_word = dsad_zero_word;
            default: raw_word = dsad_zero_word;
        endcase
    end

    // Next state: program counter, read capture, trap
    always_comb begin
        next_st = st;
        next_st.rrgn = rd_rgn;
        next_st.rlane = rd_ea[0];
        next_st.rbyte = rd_byte;
        next_st.psv = rd_req && rd_ea[dsad_psv_bit];
        next_st.trap = rd_mis || wr_mis;
        if (pc_load) begin
            next_st.pc = {pc_load_value[23:1], 1'b0};
        end else if (pc_advance) begin
            next_st.pc = st.pc + dsad_pc_step;
        end else if (pc_retreat) begin
            next_st.pc = st.pc - dsad_pc_step;
        end
    end

    // Read data: byte picked by lane and placed low
    always_comb begin
        rd_data = raw_word;
        if (st.rbyte) begin
            rd_data = {8'h00, st.rlane ? raw_word[15:8] : raw_word[7:0]};
        end
    end

    assign rd_psv_sel = st.psv;
    assign address_error_trap = st.trap;
    assign program_counter = st.pc;
    assign pc_in_vector_area = st.pc < dsad_user_base;
    assign pc_in_alt_table = (st.pc >= dsad_aivt_base) && (st.pc <= dsad_aivt_last);

    // Program word split into lower and upper halves
    assign prog_lower_word = prog_word_in[15:0];
    assign prog_upper_word = {dsad_pc_top_unimpl, prog_word_in[23:16]};

    // Pointer post-increment
    always_comb begin
        next_pointer = source_pointer_register;
        if (ptr_post_inc) begin
            next_pointer = source_pointer_register +
                (rd_byte ? dsad_ptr_step_byte : dsad_ptr_step_word);
        end
    end

    // Working register byte load and extends
    always_comb begin
        wreg_new = wreg_old;
        unique case (ext_op)
            dsad_ext_sign: wreg_new = {{8{wreg_old[7]}}, wreg_old[7:0]};
            dsad_ext_zero: wreg_new = {8'h00, wreg_old[7:0]};
            default: begin
                if (rd_byte) begin
                    wreg_new = {wreg_old[15:8], rd_data[7:0]};
                end else begin
                    wreg_new = rd_data;
                end
            end
        endcase
    end

    // State register, program counter from zero after reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '{pc: dsad_reset_addr, psv: 1'b0, trap: 1'b0,
                    rrgn: dsad_rgn_none, rlane: 1'b0, rbyte: 1'b0};
        end else begin
            st <= next_st;
        end
    end
endmodule

// >>> design/dsad_pkg.sv
// Functional notes
// - Program words are 24 bits: even lower word, odd upper word, top byte absent.
// - Program counter stays on even lower word, steps by two per word.
// - Reset starts at program address zero; image puts a jump there.
// - Program addresses below 0x000200 hold reset, primary and alternate vector tables.
// - Data effective addresses are 16-bit byte addresses over a 64 KB space.
// - Top address bit clear maps to data memory; set goes to visibility window.
// - At most 8 KB implemented; reads outside it return zero.
// - Low byte at even address, high byte at odd address.
// - Pointer post-increment adds one for bytes, two for words.
// - Byte read fetches the word, picks by bit zero, returns on low lane.
// - Shared word decode with separate byte write strobes per lane.
// - Word access to an odd address raises an address error trap.
// - Misaligned read completes, misaligned write is suppressed, trap follows.
// - Byte load into a working register changes only its low byte.
// - Sign-extend widens signed byte to 16 bits; zero-extend clears high byte.
// - Lowest 2 KB are special function registers; unused ones read zero.
// - First 8 KB reachable by 13-bit direct field; all by 16-bit or indirect.
// - Dual-ported DMA RAM of 1 or 2 KB at top of X space, both ports concurrent.
// - Same-location same-cycle writes: the CPU takes precedence.
// - DMA accesses never stall the CPU nor use its bus cycles.
package dsad_pkg;
    localparam logic [23:0] dsad_reset_addr = 24'h00_0000;
    localparam logic [23:0] dsad_goto_target_addr = 24'h00_0002;
    localparam logic [23:0] dsad_ivt_base = 24'h00_0004;
    localparam logic [23:0] dsad_ivt_last = 24'h00_00FF;
    localparam logic [23:0] dsad_aivt_base = 24'h00_0100;
    localparam logic [23:0] dsad_aivt_last = 24'h00_01FF;
    localparam logic [23:0] dsad_user_base = 24'h00_0200;
    localparam logic [23:0] dsad_pc_step = 24'h00_0002;
    localparam logic [15:0] dsad_sfr_last = 16'h07FF;
    localparam logic [15:0] dsad_near_last = 16'h1FFF;
    localparam logic [15:0] dsad_ram_limit = 16'h2000;
    localparam int dsad_psv_bit = 15;
    localparam int dsad_near_field_bits = 13;
    localparam int dsad_dma_bytes_default = 2048;
    localparam logic [15:0] dsad_ptr_step_byte = 16'h0001;
    localparam logic [15:0] dsad_ptr_step_word = 16'h0002;
    localparam logic [15:0] dsad_zero_word = 16'h0000;
    localparam logic [7:0] dsad_pc_top_unimpl = 8'h00;

    typedef enum logic [2:0] {
        dsad_ext_none = 3'b001,
        dsad_ext_sign = 3'b010,
        dsad_ext_zero = 3'b100
    } dsad_ext_t;
endpackage

// >>> design/dsad_dma_if.sv
`timescale 1ns/1ns
// Second port of the DMA RAM as seen from the DMA controller side
interface dsad_dma_if #(parameter int AW = 10);
    logic wr;
    logic [AW-1:0] waddr;
    logic [AW-1:0] raddr;
    logic [1:0] be;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic dropped;
    modport ram (input wr, waddr, raddr, be, wdata, output rdata, dropped);
    modport ctrl (output wr, waddr, raddr, be, wdata, input rdata, dropped);
endinterface

// >>> design/dsad_dma_ram.sv
`timescale 1ns/1ns
// Dual-ported word RAM with byte lanes; CPU port wins collisions
module dsad_dma_ram
    import dsad_pkg::*;
#(
    parameter int AW = 10
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cpu_wr,
    input wire logic [AW-1:0] cpu_waddr,
    input wire logic [AW-1:0] cpu_raddr,
    input wire logic [1:0] cpu_be,
    input wire logic [15:0] cpu_wdata,
    output logic [15:0] cpu_rdata,
    dsad_dma_if.ram dma
);
    typedef struct packed {
        logic [(1<<AW)-1:0][15:0] mem;
        logic [15:0] cpu_q;
        logic [15:0] dma_q;
        logic dropped;
    } dsad_ram_state_t;

    dsad_ram_state_t st;
    dsad_ram_state_t next_st;
    logic collide;

    assign collide = cpu_wr && dma.wr && (cpu_waddr == dma.waddr);
    assign cpu_rdata = st.cpu_q;
    assign dma.rdata = st.dma_q;
    assign dma.dropped = st.dropped;

    // Both ports read and write each cycle; no stall path exists
    always_comb begin
        next_st = st;
        next_st.cpu_q = st.mem[cpu_raddr];
        next_st.dma_q = st.mem[dma.raddr];
        next_st.dropped = collide;
        for (int b = 0; b < 2; b++) begin
            if (dma.wr && dma.be[b] && !collide) begin
                next_st.mem[dma.waddr][b*8 +: 8] = dma.wdata[b*8 +: 8];
            end
            if (cpu_wr && cpu_be[b]) begin
                next_st.mem[cpu_waddr][b*8 +: 8] = cpu_wdata[b*8 +: 8];
            end
        end
    end

    // State register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// >>> testbench/dsad_sfr_model.sv
`timescale 1ns/1ns
// Peripheral register block answering the decoder's register port
module dsad_sfr_model (
    input wire logic core_clk,
    input wire logic sfr_wr,
    input wire logic [10:1] sfr_waddr,
    input wire logic [1:0] sfr_wbe,
    input wire logic [15:0] sfr_wdata,
    input wire logic [10:1] sfr_raddr,
    output logic [15:0] sfr_rdata,
    output logic sfr_rhit
);
    logic [15:0] mode_reg = 16'h0000;
    initial sfr_rdata = 16'h5A5A;
    initial sfr_rhit = 1'b0;
    // One register at byte address 0x0002; a miss toggles the data lines
    always @(posedge core_clk) begin
        if (sfr_wr && sfr_waddr == 10'h001 && sfr_wbe[0]) mode_reg[7:0] <= sfr_wdata[7:0];
        if (sfr_wr && sfr_waddr == 10'h001 && sfr_wbe[1]) mode_reg[15:8] <= sfr_wdata[15:8];
        sfr_rhit <= (sfr_raddr == 10'h001);
        sfr_rdata <= (sfr_raddr == 10'h001) ? mode_reg : ~sfr_rdata;
    end
endmodule

// >>> testbench/dsad_monitor.sv
`timescale 1ns/1ns
// Port-level checks of the data space decoder
module dsad_monitor
    import dsad_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic pc_advance,
    input wire logic pc_load,
    input wire logic [23:0] program_counter,
    input wire logic rd_req,
    input wire logic rd_byte,
    input wire logic rd_near_direct,
    input wire logic [15:0] rd_effective_address,
    input wire logic [15:0] rd_data,
    input wire logic rd_psv_sel,
    input wire logic wr_req,
    input wire logic wr_byte,
    input wire logic wr_near_direct,
    input wire logic [15:0] wr_effective_address,
    input wire logic sfr_wr,
    input wire logic [1:0] sfr_wbe,
    input wire logic address_error_trap,
    input wire logic dma_wr,
    input wire logic dma_write_dropped
);
    logic wr_odd;
    logic rd_odd;
    // Word accesses at odd addresses
    assign wr_odd = wr_req && !wr_byte && wr_effective_address[0];
    assign rd_odd = rd_req && !rd_byte && rd_effective_address[0];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    trap_on_odd_a: assert property (wr_odd |=> address_error_trap)
        else $error("no trap after odd word write");
    trap_cause_a: assert property (address_error_trap |-> $past(wr_odd || rd_odd))
        else $error("trap without odd word access");
    write_blocked_a: assert property (wr_odd |-> !sfr_wr)
        else $error("odd word write reached registers");
    byte_lane_a: assert property (wr_req && wr_byte && !wr_near_direct &&
        wr_effective_address < 16'h0800 |-> sfr_wr && sfr_wbe ==
        {wr_effective_address[0], !wr_effective_address[0]})
        else $error("byte write strobe on wrong lane");
    psv_zero_a: assert property (rd_req && !rd_near_direct && rd_effective_address[15] |=>
        rd_psv_sel && rd_data == 16'h0000)
        else $error("visibility read not routed");
    unimpl_zero_a: assert property (rd_req && !rd_near_direct &&
        rd_effective_address[15:13] != 3'h0 |=> rd_data == 16'h0000)
        else $error("unimplemented read not zero");
    byte_high_a: assert property (rd_req && rd_byte |=> rd_data[15:8] == 8'h00)
        else $error("byte read high lane not clear");
    pc_step_a: assert property (pc_advance && !pc_load |=>
        program_counter == $past(program_counter) + 24'h00_0002)
        else $error("program counter step wrong");
    drop_cause_a: assert property (dma_write_dropped |-> $past(dma_wr && wr_req))
        else $error("dma drop without collision");
    trap_seen_c: cover property (address_error_trap);
    drop_seen_c: cover property (dma_write_dropped);
    psv_seen_c: cover property (rd_psv_sel);
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", nm, ex, got); end end
module tb import dsad_pkg::*;;
    logic core_clk = 1'b0, rst = 1'b1, pc_advance = '0, pc_retreat = '0, pc_load = '0;
    logic rd_req = '0, rd_byte = '0, rd_near_direct = '0, wr_req = '0, wr_byte = '0;
    logic wr_near_direct = '0, ptr_post_inc = '0, dma_wr = '0, pc_in_vector_area;
    logic pc_in_alt_table, rd_psv_sel, sfr_wr, sfr_rhit, address_error_trap, dma_write_dropped;
    logic [23:0] pc_load_value = '0, prog_word_in = '0, program_counter;
    logic [15:0] rd_effective_address = '0, wr_effective_address = '0, wr_data = '0, rd_data;
    logic [15:0] source_pointer_register = '0, wreg_old = '0, next_pointer, wreg_new;
    logic [15:0] dma_wdata = '0, dma_rdata, prog_lower_word, prog_upper_word, sfr_wdata;
    logic [15:0] sfr_rdata;
    logic [10:1] sfr_waddr, sfr_raddr;
    logic [9:0] dma_waddr = '0, dma_raddr = '0;
    logic [2:0] ext_op = 3'b001;
    logic [1:0] sfr_wbe, dma_be = '0;
    int fail_count = 0, checks = 0, cycles = 0;
    dsad_decoder dut (.*);
    dsad_sfr_model sfr (.*);
    always #5 core_clk = ~core_clk;
    // Cut a hang short
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic rd(input logic [15:0] a, input logic b, input logic nd, input logic [15:0] ex);
        @(posedge core_clk);
        rd_req <= 1'b1;
        rd_effective_address <= a;
        rd_byte <= b;
        rd_near_direct <= nd;
        @(posedge core_clk);
        rd_req <= 1'b0;
        #1;
        `CHK("rd_data", ex, rd_data)
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic b);
        @(posedge core_clk);
        wr_req <= 1'b1;
        wr_effective_address <= a;
        wr_data <= d;
        wr_byte <= b;
        @(posedge core_clk);
        wr_req <= 1'b0;
        #1;
    endtask
    task automatic dw(input logic [9:0] i, input logic [15:0] d);
        @(posedge core_clk);
        dma_wr <= 1'b1;
        dma_waddr <= i;
        dma_be <= 2'b11;
        dma_wdata <= d;
        @(posedge core_clk);
        dma_wr <= 1'b0;
    endtask
    task automatic t_pc();
        `CHK("pc", 24'h00_0000, program_counter)
        `CHK("vec", 1'b1, pc_in_vector_area)
        @(posedge core_clk);
        pc_advance <= 1'b1;
        repeat (3) @(posedge core_clk);
        pc_advance <= 1'b0;
        pc_retreat <= 1'b1;
        prog_word_in <= 24'hAB_CDEF;
        @(posedge core_clk);
        pc_retreat <= 1'b0;
        pc_load <= 1'b1;
        pc_load_value <= 24'h00_0101;
        #1;
        `CHK("pc", 24'h00_0004, program_counter)
        `CHK("lower", 16'hCDEF, prog_lower_word)
        `CHK("upper", 16'h00AB, prog_upper_word)
        @(posedge core_clk);
        pc_load <= 1'b0;
        #1;
        `CHK("alt", 1'b1, pc_in_alt_table)
    endtask
    task automatic t_mem();
        wr(16'h0003, 16'h005A, 1'b1);
        rd(16'h0002, 1'b0, 1'b0, 16'h5A00);
        rd(16'h0003, 1'b1, 1'b0, 16'h005A);
        rd(16'h0100, 1'b0, 1'b0, 16'h0000);
        wr(16'h0900, 16'h1234, 1'b0);
        wr(16'h0901, 16'h00FF, 1'b1);
        rd(16'h0900, 1'b0, 1'b0, 16'hFF34);
        wr(16'h0902, 16'h0000, 1'b0);
        wr(16'h0903, 16'hBEEF, 1'b0);
        `CHK("trap", 1'b1, address_error_trap)
        rd(16'h0902, 1'b0, 1'b0, 16'h0000);
        rd(16'h8000, 1'b0, 1'b0, 16'h0000);
        `CHK("psv", 1'b1, rd_psv_sel)
        rd(16'h3000, 1'b0, 1'b0, 16'h0000);
        rd(16'hE900, 1'b0, 1'b1, 16'hFF34);
    endtask
    task automatic t_ops();
        @(posedge core_clk);
        source_pointer_register <= 16'h1000;
        ptr_post_inc <= 1'b1;
        rd_byte <= 1'b1;
        wreg_old <= 16'h1280;
        ext_op <= dsad_ext_sign;
        #1;
        `CHK("ptr", 16'h1001, next_pointer)
        `CHK("sext", 16'hFF80, wreg_new)
        @(posedge core_clk);
        rd_byte <= 1'b0;
        ext_op <= dsad_ext_zero;
        #1;
        `CHK("ptr", 16'h1002, next_pointer)
        `CHK("zext", 16'h0080, wreg_new)
        // Byte load keeps the high byte; low byte comes from word 0x0900
        @(posedge core_clk);
        ext_op <= dsad_ext_none;
        rd_byte <= 1'b1;
        #1;
        `CHK("bload", 16'h1234, wreg_new)
    endtask
    task automatic t_dma();
        dw(10'h005, 16'hAAAA);
        rd(16'h180A, 1'b0, 1'b0, 16'hAAAA);
        fork
            wr(16'h180A, 16'h1111, 1'b0);
            dw(10'h005, 16'h2222);
        join
        `CHK("drop", 1'b1, dma_write_dropped)
        fork
            rd(16'h180A, 1'b0, 1'b0, 16'h1111);
            dw(10'h006, 16'h3333);
        join
        @(posedge core_clk);
        dma_raddr <= 10'h005;
        @(posedge core_clk);
        #1;
        `CHK("dma_rdata", 16'h1111, dma_rdata)
    endtask
    // Reset, then every scenario in turn
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        t_pc();
        t_mem();
        t_ops();
        t_dma();
        tally_and_finish();
    end
endmodule
bind dsad_decoder dsad_monitor mon (.*);
